// File: rtl/power_seq_pkg.sv
// Purpose: Shared constants and types for the sleep and standby sequencer.
// Assumes: One system clock; every count is in system clock states.
// Notes:   The long settling waits are defaults here; the top may override them.
package power_seq_pkg;

  // Settling counter width, wide enough for the longest wait
  localparam int SETTLE_CNT_W = 18;

  // Codes of the settling wait select field
  localparam logic [2:0] SETTLE_SEL_8K   = 3'h0;
  localparam logic [2:0] SETTLE_SEL_16K  = 3'h1;
  localparam logic [2:0] SETTLE_SEL_32K  = 3'h2;
  localparam logic [2:0] SETTLE_SEL_64K  = 3'h3;
  localparam logic [2:0] SETTLE_SEL_128K = 3'h4;
  localparam logic [2:0] SETTLE_SEL_1K   = 3'h5;

  // Waits in states for each select code
  localparam int unsigned WAIT_STATES_8K   = 8192;
  localparam int unsigned WAIT_STATES_16K  = 16384;
  localparam int unsigned WAIT_STATES_32K  = 32768;
  localparam int unsigned WAIT_STATES_64K  = 65536;
  localparam int unsigned WAIT_STATES_128K = 131072;
  localparam int unsigned WAIT_STATES_1K   = 1024;

  // Reset values of the system control fields
  localparam logic       STANDBY_SELECT_RST = 1'b0;
  localparam logic [2:0] SETTLE_SELECT_RST  = 3'h0;

  // Number of interrupt sources that can wake sleep mode
  localparam int INT_SRC_N = 8;
  // Number of peripheral modules with a halt bit
  localparam int MODULE_N  = 4;

  // Power states of the device
  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_SW_STANDBY,
    ST_SETTLE,
    ST_RESET_HOLD,
    ST_HW_STANDBY
  } power_state_t;

endpackage

// File: rtl/settle_timer.sv
// Purpose: Down-counter that times the oscillator settling wait.
// Assumes: load_value_in is at least 1.
// Notes:   done_out is high in the last state of the wait.
`timescale 1ns/1ps
module settle_timer
  import power_seq_pkg::*;
(
  input  wire logic                    ref_clk_in,    // System clock
  input  wire logic                    rst_b_in,      // Asynchronous reset, low
  input  wire logic                    load_in,       // Start a new wait
  input  wire logic [SETTLE_CNT_W-1:0] load_value_in, // Wait length in states
  output logic                         done_out       // Last state of the wait
);

  logic [SETTLE_CNT_W-1:0] cnt_reg; // Remaining states, zero when idle

  // Load on wake, then count down and stop at zero
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_reg <= '0;
    end else if (load_in) begin
      cnt_reg <= load_value_in;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - SETTLE_CNT_W'(1);
    end
  end

  // The counter reaches zero on the edge after this state
  assign done_out = (cnt_reg == SETTLE_CNT_W'(1));

endmodule

// File: rtl/sleep_standby_ctrl.sv
// Purpose: Power-down sequencer for sleep and software standby.
// Assumes: All inputs but rst_b_in are synchronous to ref_clk_in; pins are active low.
// Notes:   Rules below.
`timescale 1ns/1ps
module sleep_standby_ctrl
  import power_seq_pkg::*;
#(
  // Long waits, shortened only for simulation
  parameter int unsigned WAIT_8K   = WAIT_STATES_8K,
  parameter int unsigned WAIT_16K  = WAIT_STATES_16K,
  parameter int unsigned WAIT_32K  = WAIT_STATES_32K,
  parameter int unsigned WAIT_64K  = WAIT_STATES_64K,
  parameter int unsigned WAIT_128K = WAIT_STATES_128K
) (
  input  wire logic                 ref_clk_in,                 // System clock
  input  wire logic                 rst_b_in,                   // Async reset, low
  input  wire logic                 sleep_exec_in,              // Low-power instruction done
  input  wire logic                 sysctl_wr_in,               // Write control fields
  input  wire logic                 standby_select_wdata_in,    // New select bit
  input  wire logic [2:0]           settle_wait_select_wdata_in, // New wait select
  input  wire logic                 external_init_pin_b_in,     // Reset pin, low
  input  wire logic                 hardware_powerdown_pin_b_in, // Standby pin, low
  input  wire logic                 nmi_in,                     // NMI request
  input  wire logic                 ext_int_line_0_in,          // Line 0 request
  input  wire logic                 ext_int_line_1_in,          // Line 1 request
  input  wire logic                 ext_int_0_en_in,            // Line 0 enable bit
  input  wire logic                 ext_int_1_en_in,            // Line 1 enable bit
  input  wire logic                 ext_int_0_cpu_mask_in,      // Line 0 masked in CPU
  input  wire logic                 ext_int_1_cpu_mask_in,      // Line 1 masked in CPU
  input  wire logic [INT_SRC_N-1:0] int_src_req_in,             // Other sources pending
  input  wire logic [INT_SRC_N-1:0] int_src_en_in,              // Enabled in own module
  input  wire logic [INT_SRC_N-1:0] int_src_masked_in,          // Masked by priority+mask
  input  wire logic [MODULE_N-1:0]  module_halt_in,             // Module halt settings

  output logic                      standby_select_bit_out,     // Select bit value
  output logic [2:0]                settle_wait_select_out,     // Wait select value
  output logic                      cpu_halt_out,               // CPU stopped
  output logic                      cpu_regs_hold_out,          // CPU registers frozen
  output logic                      osc_enable_out,             // Oscillator running
  output logic                      chip_clock_en_out,          // Clocks supplied to chip
  output logic [MODULE_N-1:0]       module_run_out,             // Per-module run
  output logic                      module_reset_out,           // Peripherals held reset
  output logic                      io_hold_out,                // Port settings frozen
  output logic                      ram_retain_out,             // RAM retention mode
  output logic                      device_reset_out,           // Device in reset state
  output logic                      hw_standby_out,             // Hardware standby mode
  output logic                      int_exception_start_out,    // Interrupt handling, pulse
  output logic                      reset_exception_start_out,  // Reset handling, pulse
  output logic [2:0]                power_state_out             // Current state code
);

  power_state_t            state_reg;          // Current power state
  power_state_t            state_next;         // Next power state
  logic                    standby_select_reg; // Standby select bit
  logic [2:0]              settle_select_reg;  // Settling wait select

  logic                    sleep_wake;         // Any sleep wake source
  logic                    standby_wake;       // Any standby wake source
  logic                    settle_load;        // Start of settling wait
  logic                    settle_done;        // Last settling state
  logic [SETTLE_CNT_W-1:0] settle_len;         // Chosen wait in states

  // Wait length for a select code; illegal codes take the WAIT_128K wait
  function automatic logic [SETTLE_CNT_W-1:0] wait_lookup(input logic [2:0] sel);
    logic [SETTLE_CNT_W-1:0] len;
    len = SETTLE_CNT_W'(WAIT_128K);

    unique case (sel)
      SETTLE_SEL_8K:   len = SETTLE_CNT_W'(WAIT_8K);
      SETTLE_SEL_16K:  len = SETTLE_CNT_W'(WAIT_16K);
      SETTLE_SEL_32K:  len = SETTLE_CNT_W'(WAIT_32K);
      SETTLE_SEL_64K:  len = SETTLE_CNT_W'(WAIT_64K);
      SETTLE_SEL_128K: len = SETTLE_CNT_W'(WAIT_128K);
      SETTLE_SEL_1K:   len = SETTLE_CNT_W'(WAIT_STATES_1K);
      default:         len = SETTLE_CNT_W'(WAIT_128K); // Safe choice
    endcase
    return len;
  endfunction

  // Sleep wakes on NMI or on a source both enabled and unmasked
  assign sleep_wake = nmi_in
                    | (|(int_src_req_in & int_src_en_in & ~int_src_masked_in));

  // Standby wakes only on NMI or an enabled, unmasked external line
  assign standby_wake = nmi_in
                      | (ext_int_line_0_in & ext_int_0_en_in & ~ext_int_0_cpu_mask_in)
                      | (ext_int_line_1_in & ext_int_1_en_in & ~ext_int_1_cpu_mask_in);

  assign settle_len  = wait_lookup(settle_select_reg);
  // A new wake always reloads the timer
  assign settle_load = (state_reg == ST_SW_STANDBY) && (state_next == ST_SETTLE);

  // Settling wait timer
  settle_timer u_settle_timer (
    .ref_clk_in    (ref_clk_in),
    .rst_b_in      (rst_b_in),
    .load_in       (settle_load),
    .load_value_in (settle_len),
    .done_out      (settle_done)
  );

  // Next state; the standby pin outranks the reset pin, which outranks all else
  always_comb begin
    state_next = state_reg;

    if (!hardware_powerdown_pin_b_in) begin
      state_next = ST_HW_STANDBY;
    end else if (!external_init_pin_b_in) begin
      state_next = ST_RESET_HOLD;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          // Instruction picks the mode from the select bit
          if (sleep_exec_in) begin
            if (standby_select_reg) begin
              state_next = ST_SW_STANDBY;
            end else begin
              state_next = ST_SLEEP;
            end
          end
        end

        ST_SLEEP: begin
          // Accepted interrupt resumes execution
          if (sleep_wake) begin
            state_next = ST_RUN;
          end
        end

        ST_SW_STANDBY: begin
          // Restart the oscillator and start the wait
          if (standby_wake) begin
            state_next = ST_SETTLE;
          end
        end

        ST_SETTLE: begin
          // Release only once the wait has run out
          if (settle_done) begin
            state_next = ST_RUN;
          end
        end

        ST_RESET_HOLD: begin
          // Pin is high here, so reset handling begins
          state_next = ST_RUN;
        end

        ST_HW_STANDBY: begin
          // Leaving hardware standby goes through the reset state
          state_next = ST_RESET_HOLD;
        end

        default: begin
          state_next = ST_RESET_HOLD; // Recover from an illegal code
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= ST_RESET_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  // System control fields; writes only land while the CPU runs
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      standby_select_reg <= STANDBY_SELECT_RST;
      settle_select_reg  <= SETTLE_SELECT_RST;
    end else if (state_next == ST_RESET_HOLD || state_next == ST_HW_STANDBY) begin
      // Reset and hardware standby restore the initial values
      standby_select_reg <= STANDBY_SELECT_RST;
      settle_select_reg  <= SETTLE_SELECT_RST;
    end else if (sysctl_wr_in && state_reg == ST_RUN) begin
      // The bit is never cleared by a wake; a write of 0, reset or hardware standby clears it
      standby_select_reg <= standby_select_wdata_in;
      settle_select_reg  <= settle_wait_select_wdata_in;
    end
  end

  // Control outputs, registered from the next state
  // Same edge as the state code
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cpu_halt_out      <= 1'b1;
      cpu_regs_hold_out <= 1'b0;
      osc_enable_out    <= 1'b1;
      chip_clock_en_out <= 1'b1;
      module_run_out    <= '0;
      module_reset_out  <= 1'b1;
      io_hold_out       <= 1'b0;
      ram_retain_out    <= 1'b0;
      device_reset_out  <= 1'b1;
      hw_standby_out    <= 1'b0;
    end else begin
      unique case (state_next)
        ST_RUN: begin
          cpu_halt_out      <= 1'b0;
          cpu_regs_hold_out <= 1'b0;
          osc_enable_out    <= 1'b1;
          chip_clock_en_out <= 1'b1;
          module_run_out    <= ~module_halt_in;
          module_reset_out  <= 1'b0;
          io_hold_out       <= 1'b0;
          ram_retain_out    <= 1'b0;
          device_reset_out  <= 1'b0;
          hw_standby_out    <= 1'b0;
        end

        ST_SLEEP: begin
          // CPU frozen, peripherals keep running unless halted
          cpu_halt_out      <= 1'b1;
          cpu_regs_hold_out <= 1'b1;
          osc_enable_out    <= 1'b1;
          chip_clock_en_out <= 1'b1;
          module_run_out    <= ~module_halt_in;
          module_reset_out  <= 1'b0;
          io_hold_out       <= 1'b0;
          ram_retain_out    <= 1'b0;
          device_reset_out  <= 1'b0;
          hw_standby_out    <= 1'b0;
        end

        ST_SW_STANDBY: begin
          // Everything stops; state of CPU, RAM and ports is kept
          cpu_halt_out      <= 1'b1;
          cpu_regs_hold_out <= 1'b1;
          osc_enable_out    <= 1'b0;
          chip_clock_en_out <= 1'b0;
          module_run_out    <= '0;
          module_reset_out  <= 1'b1;
          io_hold_out       <= 1'b1;
          ram_retain_out    <= 1'b1;
          device_reset_out  <= 1'b0;
          hw_standby_out    <= 1'b0;
        end

        ST_SETTLE: begin
          // Oscillator restarts, clocks stay gated until the wait ends
          cpu_halt_out      <= 1'b1;
          cpu_regs_hold_out <= 1'b1;
          osc_enable_out    <= 1'b1;
          chip_clock_en_out <= 1'b0;
          module_run_out    <= '0;
          module_reset_out  <= 1'b1;
          io_hold_out       <= 1'b1;
          ram_retain_out    <= 1'b1;
          device_reset_out  <= 1'b0;
          hw_standby_out    <= 1'b0;
        end

        ST_RESET_HOLD: begin
          // Clocks at once; the pin holder covers oscillator settling
          cpu_halt_out      <= 1'b1;
          cpu_regs_hold_out <= 1'b0;
          osc_enable_out    <= 1'b1;
          chip_clock_en_out <= 1'b1;
          module_run_out    <= '0;
          module_reset_out  <= 1'b1;
          io_hold_out       <= 1'b0;
          ram_retain_out    <= 1'b0;
          device_reset_out  <= 1'b1;
          hw_standby_out    <= 1'b0;
        end

        ST_HW_STANDBY: begin
          // Standby flag, CPU halt and peripheral reset are up; all else is down
          cpu_halt_out      <= 1'b1;
          cpu_regs_hold_out <= 1'b0;
          osc_enable_out    <= 1'b0;
          chip_clock_en_out <= 1'b0;
          module_run_out    <= '0;
          module_reset_out  <= 1'b1;
          io_hold_out       <= 1'b0;
          ram_retain_out    <= 1'b0;
          device_reset_out  <= 1'b0;
          hw_standby_out    <= 1'b1;
        end

        default: begin
          cpu_halt_out      <= 1'b1;
          cpu_regs_hold_out <= 1'b0;
          osc_enable_out    <= 1'b1;
          chip_clock_en_out <= 1'b1;
          module_run_out    <= '0;
          module_reset_out  <= 1'b1;
          io_hold_out       <= 1'b0;
          ram_retain_out    <= 1'b0;
          device_reset_out  <= 1'b1;
          hw_standby_out    <= 1'b0;
        end
      endcase
    end
  end

  // Exception start pulses, one cycle on the return to execution
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      int_exception_start_out   <= 1'b0;
      reset_exception_start_out <= 1'b0;
    end else begin
      int_exception_start_out   <= (state_next == ST_RUN)
                                 && (state_reg == ST_SLEEP || state_reg == ST_SETTLE);
      reset_exception_start_out <= (state_next == ST_RUN)
                                 && (state_reg == ST_RESET_HOLD);
    end
  end

  // Visible copies of the control fields and the state
  assign standby_select_bit_out = standby_select_reg;
  assign settle_wait_select_out = settle_select_reg;
  assign power_state_out        = state_reg;

endmodule

// File: bench/power_seq_sva.sv
// Purpose: Concurrent checks on the sleep and standby sequencer ports.
// Assumes: Waits follow the parameters handed on by the bind.
// Notes:   Select codes 11x are timed with the WAIT_128K wait.
`timescale 1ns/1ps
module power_seq_sva
  import power_seq_pkg::*;
#(
  parameter int unsigned WAIT_8K   = 20,
  parameter int unsigned WAIT_16K  = 30,
  parameter int unsigned WAIT_32K  = 40,
  parameter int unsigned WAIT_64K  = 50,
  parameter int unsigned WAIT_128K = 60
) (
  input wire logic                 ref_clk_in,
  input wire logic                 rst_b_in,
  input wire logic                 sleep_exec_in,
  input wire logic                 external_init_pin_b_in,
  input wire logic                 hardware_powerdown_pin_b_in,
  input wire logic                 nmi_in,
  input wire logic                 ext_int_line_0_in,
  input wire logic                 ext_int_line_1_in,
  input wire logic                 ext_int_0_en_in,
  input wire logic                 ext_int_1_en_in,
  input wire logic                 ext_int_0_cpu_mask_in,
  input wire logic                 ext_int_1_cpu_mask_in,
  input wire logic [INT_SRC_N-1:0] int_src_req_in,
  input wire logic [INT_SRC_N-1:0] int_src_en_in,
  input wire logic [INT_SRC_N-1:0] int_src_masked_in,
  input wire logic [MODULE_N-1:0]  module_halt_in,
  input wire logic                 standby_select_bit_out,
  input wire logic [2:0]           settle_wait_select_out,
  input wire logic                 cpu_halt_out,
  input wire logic                 cpu_regs_hold_out,
  input wire logic                 osc_enable_out,
  input wire logic                 chip_clock_en_out,
  input wire logic [MODULE_N-1:0]  module_run_out,
  input wire logic                 module_reset_out,
  input wire logic                 io_hold_out,
  input wire logic                 ram_retain_out,
  input wire logic                 device_reset_out,
  input wire logic                 hw_standby_out,
  input wire logic                 int_exception_start_out,
  input wire logic                 reset_exception_start_out,
  input wire logic [2:0]           power_state_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  logic        pins_ok;   // Both pins released
  logic [17:0] wait_n;    // Expected settling length
  logic [17:0] cnt_reg;   // States spent settling
  assign pins_ok = external_init_pin_b_in & hardware_powerdown_pin_b_in;
  // Wait length per select code; illegal codes take WAIT_128K
  always_comb begin
    case (settle_wait_select_out)
      3'h0:    wait_n = 18'(WAIT_8K);
      3'h1:    wait_n = 18'(WAIT_16K);
      3'h2:    wait_n = 18'(WAIT_32K);
      3'h3:    wait_n = 18'(WAIT_64K);
      3'h5:    wait_n = 18'h00400;
      default: wait_n = 18'(WAIT_128K);
    endcase
  end
  // Counts settling states so the release moment can be pinned down
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_reg <= 18'h0;
    end else if (power_state_out == ST_SETTLE) begin
      cnt_reg <= cnt_reg + 18'h1;
    end else begin
      cnt_reg <= 18'h0;
    end
  end
  sequence run_exec_s;
    power_state_out == ST_RUN && sleep_exec_in && pins_ok;
  endsequence
  sequence settle_done_s;
    power_state_out == ST_SETTLE ##1 power_state_out == ST_RUN;
  endsequence
  sleep_entry_a: assert property (run_exec_s and !standby_select_bit_out |=>
    power_state_out == ST_SLEEP && cpu_halt_out && cpu_regs_hold_out) else $error("no sleep");
  standby_entry_a: assert property (run_exec_s and standby_select_bit_out |=>
    power_state_out == ST_SW_STANDBY && !osc_enable_out && !chip_clock_en_out && module_reset_out
    && module_run_out == '0 && io_hold_out && ram_retain_out) else $error("no standby");
  sleep_modules_a: assert property (power_state_out == ST_SLEEP &&
    $stable(module_halt_in) |-> module_run_out == ~module_halt_in) else $error("module run wrong");
  sleep_wake_a: assert property (power_state_out == ST_SLEEP && pins_ok && nmi_in |=>
    power_state_out == ST_RUN && int_exception_start_out) else $error("sleep not woken");
  sleep_hold_a: assert property (power_state_out == ST_SLEEP && pins_ok && !nmi_in &&
    !(|(int_src_req_in & int_src_en_in & ~int_src_masked_in)) |=> power_state_out == ST_SLEEP)
    else $error("sleep left wrongly");
  standby_hold_a: assert property (power_state_out == ST_SW_STANDBY && pins_ok &&
    !nmi_in && !(ext_int_line_0_in && ext_int_0_en_in && !ext_int_0_cpu_mask_in) &&
    !(ext_int_line_1_in && ext_int_1_en_in && !ext_int_1_cpu_mask_in) |=>
    power_state_out == ST_SW_STANDBY) else $error("standby left wrongly");
  standby_wake_a: assert property (power_state_out == ST_SW_STANDBY && pins_ok &&
    nmi_in |=> power_state_out == ST_SETTLE && osc_enable_out && !chip_clock_en_out)
    else $error("no settle");
  settle_time_a: assert property (settle_done_s |-> cnt_reg == wait_n &&
    int_exception_start_out && chip_clock_en_out) else $error("settle length wrong");
  init_pin_a: assert property (power_state_out != ST_HW_STANDBY &&
    hardware_powerdown_pin_b_in && !external_init_pin_b_in |=> power_state_out == ST_RESET_HOLD &&
    device_reset_out && chip_clock_en_out && osc_enable_out) else $error("reset pin ignored");
  powerdown_pin_a: assert property (!hardware_powerdown_pin_b_in |=>
    power_state_out == ST_HW_STANDBY && hw_standby_out) else $error("powerdown pin ignored");
  reset_exit_a: assert property (power_state_out == ST_RESET_HOLD && pins_ok |=>
    power_state_out == ST_RUN && reset_exception_start_out) else $error("no reset handling");
  select_keep_a: assert property (power_state_out inside {ST_SLEEP, ST_SW_STANDBY,
    ST_SETTLE} && pins_ok |=> $stable(standby_select_bit_out)) else $error("select bit changed");
endmodule
bind sleep_standby_ctrl power_seq_sva #(.WAIT_8K(WAIT_8K), .WAIT_16K(WAIT_16K),
  .WAIT_32K(WAIT_32K), .WAIT_64K(WAIT_64K), .WAIT_128K(WAIT_128K)) i_power_seq_sva (.*);

// File: bench/init_pin_model.sv
// Purpose: Outside party that pulls the reset pin low for a fixed time.
// Assumes: One request pulse starts one low period.
// Notes:   The hold covers the oscillator restart after standby.
`timescale 1ns/1ps
module init_pin_model #(
  parameter int HOLD = 8  // Low time in clocks
) (
  input  wire logic ref_clk_in,              // System clock
  input  wire logic rst_b_in,                // Async reset, low
  input  wire logic pulse_req_in,            // Start a low period
  output logic      external_init_pin_b_out  // Reset pin, low active
);
  logic [7:0] hold_reg;  // Clocks left low
  // Counts down the low period; the pin is only released at zero
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hold_reg <= 8'h00;
    end else if (pulse_req_in) begin
      hold_reg <= 8'(HOLD);
    end else if (hold_reg != 8'h00) begin
      hold_reg <= hold_reg - 8'h01;
    end
  end
  assign external_init_pin_b_out = (hold_reg == 8'h00);
endmodule

// File: bench/sleep_standby_ctrl_tb.sv
// Purpose: Self-checking bench for the sleep and standby sequencer.
// Assumes: Short settling waits set through the top parameters.
// Notes:   Inputs move at the falling edge, outputs are read there too.
`timescale 1ns/1ps
module sleep_standby_ctrl_tb;
  import power_seq_pkg::*;
  localparam int W8 = 20, W16 = 30, W32 = 40, W64 = 50, W128 = 60;
  logic ref_clk_in = 1'b0, rst_b_in = 1'b0, init_req = 1'b0;
  logic sleep_exec_in, sysctl_wr_in, standby_select_wdata_in, hardware_powerdown_pin_b_in;
  logic [2:0] settle_wait_select_wdata_in, settle_wait_select_out, power_state_out;
  logic external_init_pin_b_in, nmi_in, ext_int_line_0_in, ext_int_line_1_in;
  logic ext_int_0_en_in, ext_int_1_en_in, ext_int_0_cpu_mask_in, ext_int_1_cpu_mask_in;
  logic [7:0] int_src_req_in, int_src_en_in, int_src_masked_in;
  logic [3:0] module_halt_in, module_run_out;
  logic standby_select_bit_out, cpu_halt_out, cpu_regs_hold_out, osc_enable_out;
  logic chip_clock_en_out, module_reset_out, io_hold_out, ram_retain_out, device_reset_out;
  logic hw_standby_out, int_exception_start_out, reset_exception_start_out;
  int mismatches = 0, compares = 0, cycles = 0, i;
  int waits[7] = '{W8, W16, W32, W64, W128, 1024, W128};  // Code 6 is illegal
  always #50 ref_clk_in = ~ref_clk_in;
  sleep_standby_ctrl #(.WAIT_8K(W8), .WAIT_16K(W16), .WAIT_32K(W32), .WAIT_64K(W64),
    .WAIT_128K(W128)) i_sleep_standby_ctrl (.*);
  init_pin_model #(.HOLD(8)) i_init_pin_model (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .pulse_req_in(init_req), .external_init_pin_b_out(external_init_pin_b_in));
  task automatic close_out();
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard, well above the longest run
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  // Bounded wait for a state, then judge it
  task automatic wait_st(input logic [2:0] st);
    for (int k = 0; k < 40 && power_state_out !== st; k++) tick(1);
    chk(power_state_out, st);
  endtask
  // Write the control fields, then run the low-power instruction
  task automatic low_power(input logic sb, input logic [2:0] sel, input logic [2:0] want);
    sysctl_wr_in = 1'b1;
    standby_select_wdata_in = sb;
    settle_wait_select_wdata_in = sel;
    tick(1);
    sysctl_wr_in = 1'b0;
    sleep_exec_in = 1'b1;
    tick(1);
    sleep_exec_in = 1'b0;
    chk(power_state_out, want);
  endtask
  task automatic s_sleep();
    module_halt_in = 4'h5;
    low_power(1'b0, 3'h0, ST_SLEEP);
    chk(cpu_halt_out & cpu_regs_hold_out, 1'b1);
    chk(module_run_out, 4'ha);
    int_src_req_in = 8'hff;
    int_src_en_in = 8'h0f;
    int_src_masked_in = 8'h0f;
    tick(3);
    chk(power_state_out, ST_SLEEP);
    int_src_en_in = 8'h8f;
    tick(1);
    chk({power_state_out, int_exception_start_out}, {ST_RUN, 1'b1});
    int_src_req_in = 8'h00;
    low_power(1'b0, 3'h0, ST_SLEEP);
    int_src_masked_in = 8'hff;
    nmi_in = 1'b1;
    tick(1);
    nmi_in = 1'b0;
    chk({power_state_out, int_exception_start_out}, {ST_RUN, 1'b1});
  endtask
  // Reset pin and powerdown pin exits from sleep or standby
  task automatic s_pins(input logic sb);
    low_power(sb, 3'h5, sb ? ST_SW_STANDBY : ST_SLEEP);
    init_req = 1'b1;
    tick(1);
    init_req = 1'b0;
    wait_st(ST_RESET_HOLD);
    chk({device_reset_out, chip_clock_en_out, osc_enable_out}, 3'h7);
    wait_st(ST_RUN);
    chk({reset_exception_start_out, standby_select_bit_out}, 2'h2);
    low_power(sb, 3'h5, sb ? ST_SW_STANDBY : ST_SLEEP);
    hardware_powerdown_pin_b_in = 1'b0;
    tick(1);
    chk({power_state_out, hw_standby_out}, {ST_HW_STANDBY, 1'b1});
    hardware_powerdown_pin_b_in = 1'b1;
    wait_st(ST_RUN);
  endtask
  // Standby entry, refused wakes, then a timed wake from one source
  task automatic s_standby(input logic [2:0] sel, input int n, input int src);
    int cnt;
    low_power(1'b1, sel, ST_SW_STANDBY);
    chk({osc_enable_out, chip_clock_en_out, module_reset_out, module_run_out}, 7'h10);
    chk({io_hold_out, ram_retain_out}, 2'h3);
    {ext_int_line_0_in, ext_int_line_1_in} = 2'h3;
    {int_src_req_in, int_src_en_in, int_src_masked_in} = {8'hff, 8'hff, 8'h00};
    tick(3);
    chk(power_state_out, ST_SW_STANDBY);
    {ext_int_line_0_in, ext_int_line_1_in, int_src_req_in} = 10'h0;
    case (src)
      0: nmi_in = 1'b1;
      1: {ext_int_line_0_in, ext_int_0_en_in} = 2'h3;
      default: {ext_int_line_1_in, ext_int_1_cpu_mask_in} = 2'h2;
    endcase
    tick(1);
    {nmi_in, ext_int_line_0_in, ext_int_line_1_in, ext_int_0_en_in} = 4'h0;
    ext_int_1_cpu_mask_in = 1'b1;
    chk({power_state_out, osc_enable_out, chip_clock_en_out}, {ST_SETTLE, 2'h2});
    cnt = 0;
    while (power_state_out === ST_SETTLE && cnt < 2000) begin
      cnt++;
      tick(1);
    end
    chk(cnt, n);
    chk({power_state_out, int_exception_start_out, chip_clock_en_out}, {ST_RUN, 2'h3});
    chk(standby_select_bit_out, 1'b1);
  endtask
  initial begin
    {sleep_exec_in, sysctl_wr_in, standby_select_wdata_in, nmi_in} = 4'h0;
    settle_wait_select_wdata_in = 3'h0;
    hardware_powerdown_pin_b_in = 1'b1;
    {ext_int_line_0_in, ext_int_line_1_in, ext_int_0_en_in} = 3'h0;
    {ext_int_1_en_in, ext_int_0_cpu_mask_in, ext_int_1_cpu_mask_in} = 3'h5;
    {int_src_req_in, int_src_en_in, int_src_masked_in} = 24'h0;
    module_halt_in = 4'h0;
    tick(4);
    rst_b_in = 1'b1;
    tick(2);
    chk({power_state_out, standby_select_bit_out, settle_wait_select_out}, {ST_RUN,4'h0});
    s_sleep();
    s_pins(1'b0);
    s_pins(1'b1);
    for (i = 0; i < 7; i++) s_standby(i[2:0], waits[i], i % 3);
    close_out();
  end
endmodule
